// [inc/iowdt_pkg.sv]
package iowdt_pkg;
  // -------------------------------------------------------------------
  // i/o read ports
  // -------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] TIMER_DISABLE_PORT_A = 16'h0033;
  localparam logic [15:0] TIMER_DISABLE_PORT_B = 16'h0343;
  localparam logic [15:0] TIMER_TRIGGER_PORT_A = 16'h0533;
  localparam logic [15:0] TIMER_TRIGGER_PORT_B = 16'h0543;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int BASE_TIME_MS = 500;             // shortest range
  localparam int MS_PER_S = 1000;
  localparam int BASE_CYCLES = BASE_TIME_MS * (CLK_HZ / MS_PER_S);
  localparam int RANGE_SEL_W = 3;                // eight ranges, 500 ms .. 64 s
  localparam int TICKS_W = 8;                    // holds 2**7 base ticks
  localparam int PULSE_CYCLES = 16;              // length of the reset / nmi pulse
  localparam int PULSE_W = 5;
  localparam logic [7:0] TICKS_ONE = 8'h01;
  localparam logic [4:0] PULSE_ONE = 5'h01;

  // -------------------------------------------------------------------
  // control states
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STOPPED = 3'b001,
    ST_RUNNING = 3'b010,
    ST_FIRING  = 3'b100
  } iowdt_state_t;
endpackage

// [inc/iowdt_tick_if.sv]
`timescale 1ns/1ps
interface iowdt_tick_if;
  logic restart;  // clears the prescaler
  logic tick;     // one cycle every base interval
  modport ctrl (output restart, input tick);
  modport gen (input restart, output tick);
endinterface

// [logic/iowdt_prescaler.sv]
`timescale 1ns/1ps
module iowdt_prescaler #(
  parameter int TICK_CYCLES = iowdt_pkg::BASE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // tick link
  iowdt_tick_if.gen tk
);
  import iowdt_pkg::*;

  logic [31:0] count;
  logic [31:0] next_count;
  logic next_tick;
  logic baseTick;

  // -------------------------------------------------------------------
  // base interval divider
  // -------------------------------------------------------------------
  // restart zeroes the phase so a retrigger always gets a full interval
  always_comb begin
    next_count = count + 32'h00000001;
    next_tick = 1'b0;
    if (tk.restart) begin
      next_count = 32'h00000000;
    end else if (count == 32'(TICK_CYCLES - 1)) begin
      next_count = 32'h00000000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count <= 32'h00000000;
      baseTick <= 1'b0;
    end else begin
      count <= next_count;
      baseTick <= next_tick;
    end
  end

  assign tk.tick = baseTick & ~tk.restart;  // a restart swallows a tick in flight
endmodule

// [logic/io_read_watchdog_timer.sv]
`timescale 1ns/1ps
// What this block does
// - enabled timer expiring without trigger asserts reset
// - eight jumper ranges, 500 ms to 64 s
// - trigger port read enables or retriggers timer
// - disable port read stops timer, no reset
// - jumper routes expiry to nmi instead
module io_read_watchdog_timer #(
  parameter int TICK_CYCLES = iowdt_pkg::BASE_CYCLES,
  parameter int PULSE_LEN = iowdt_pkg::PULSE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // host i/o read cycle
  input wire logic [iowdt_pkg::ADDR_W-1:0] ioAddr,
  input wire logic ioRead,
  // jumper straps
  input wire logic [iowdt_pkg::RANGE_SEL_W-1:0] rangeSel,
  input wire logic nmiRouteJumper,
  // timeout outputs and status
  output logic sysReset,
  output logic nmiEvent,
  output logic timerRunning
);
  import iowdt_pkg::*;

  // -------------------------------------------------------------------
  // port decode
  // -------------------------------------------------------------------
  function automatic logic isTrigger(input logic [ADDR_W-1:0] a);
    return (a == TIMER_TRIGGER_PORT_A) || (a == TIMER_TRIGGER_PORT_B);
  endfunction

  function automatic logic isDisable(input logic [ADDR_W-1:0] a);
    return (a == TIMER_DISABLE_PORT_A) || (a == TIMER_DISABLE_PORT_B);
  endfunction

  // doubling ladder: range n is 2**n base intervals
  function automatic logic [TICKS_W-1:0] rangeTicks(input logic [RANGE_SEL_W-1:0] s);
    return TICKS_ONE << s;
  endfunction

  iowdt_tick_if tk ();

  logic trig;
  logic dis;
  // read data is never returned: the host sees undefined bus data
  assign trig = ioRead & isTrigger(ioAddr);
  assign dis = ioRead & isDisable(ioAddr);

  // the prescaler free-runs while stopped; only a trigger re-phases it
  iowdt_prescaler #(.TICK_CYCLES(TICK_CYCLES)) u_prescaler (
    .core_clk(core_clk),
    .rst(rst),
    .tk(tk)
  );

  // -------------------------------------------------------------------
  // supervision state
  // -------------------------------------------------------------------
  // counting in base ticks keeps the counter narrow; the prescaler restart
  // on every trigger keeps the interval exact to the cycle
  iowdt_state_t state;
  iowdt_state_t next_state;
  logic [TICKS_W-1:0] ticksLeft;
  logic [TICKS_W-1:0] next_ticksLeft;
  logic [PULSE_W-1:0] pulseLeft;
  logic [PULSE_W-1:0] next_pulseLeft;
  logic next_sysReset;
  logic next_nmiEvent;
  logic next_timerRunning;

  // a trigger also cancels a pulse already firing; disable wins by decode
  always_comb begin
    next_state = state;
    next_ticksLeft = ticksLeft;
    next_pulseLeft = pulseLeft;
    tk.restart = 1'b0;
    if (dis) begin
      next_state = ST_STOPPED;
    end else if (trig) begin
      next_state = ST_RUNNING;
      next_ticksLeft = rangeTicks(rangeSel);
      tk.restart = 1'b1;
    end else begin
      unique case (state)
        ST_STOPPED: begin
        end
        ST_RUNNING: begin
          if (tk.tick) begin
            if (ticksLeft == TICKS_ONE) begin
              next_state = ST_FIRING;
              next_pulseLeft = PULSE_W'(PULSE_LEN);
            end else begin
              next_ticksLeft = ticksLeft - TICKS_ONE;
            end
          end
        end
        ST_FIRING: begin
          // one shot per expiry; the timer waits stopped for a new trigger
          if (pulseLeft == PULSE_ONE) begin
            next_state = ST_STOPPED;
          end else begin
            next_pulseLeft = pulseLeft - PULSE_ONE;
          end
        end
        default: begin
          next_state = ST_STOPPED;
        end
      endcase
    end
    next_sysReset = (next_state == ST_FIRING) && !nmiRouteJumper;
    next_nmiEvent = (next_state == ST_FIRING) && nmiRouteJumper;
    next_timerRunning = (next_state == ST_RUNNING);
  end

  // outputs are registered from the next state so they glitch-free track it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_STOPPED;
      ticksLeft <= TICKS_ONE;
      pulseLeft <= PULSE_ONE;
      sysReset <= 1'b0;
      nmiEvent <= 1'b0;
      timerRunning <= 1'b0;
    end else begin
      state <= next_state;
      ticksLeft <= next_ticksLeft;
      pulseLeft <= next_pulseLeft;
      sysReset <= next_sysReset;
      nmiEvent <= next_nmiEvent;
      timerRunning <= next_timerRunning;
    end
  end

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_lastTick;
    state == ST_RUNNING && tk.tick && ticksLeft == TICKS_ONE && !trig && !dis;
  endsequence

  property p_expire;
    s_lastTick |=> (sysReset == !$past(nmiRouteJumper)) && (nmiEvent == $past(nmiRouteJumper));
  endproperty
  a_expire: assert property (p_expire) else $error("expiry did not fire output");

  property p_load;
    trig |=> ticksLeft == rangeTicks($past(rangeSel));
  endproperty
  a_load: assert property (p_load) else $error("trigger loaded wrong range");

  property p_enable;
    trig |=> timerRunning && state == ST_RUNNING;
  endproperty
  a_enable: assert property (p_enable) else $error("trigger did not enable timer");

  property p_disable;
    dis ##1 !trig [*2] |-> !sysReset && !nmiEvent && !timerRunning;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not stop timer");

  property p_exclusive;
    !(sysReset && nmiEvent);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("reset and nmi both high");

  property p_restart;
    trig ##1 (!trig && !dis) [*3] |-> ticksLeft == $past(ticksLeft, 2);
  endproperty
  a_restart: assert property (p_restart) else $error("count moved right after trigger");

  property p_noSilentFire;
    $rose(sysReset) |-> $past(state) == ST_RUNNING;
  endproperty
  a_noSilentFire: assert property (p_noSilentFire) else $error("reset without running timer");

  // ordinary base tick: one base tick off the count, still running
  sequence s_midTick;
    state == ST_RUNNING && tk.tick && ticksLeft != TICKS_ONE && !trig && !dis;
  endsequence

  // last cycle of an expiry pulse with nobody touching the ports
  sequence s_lastPulse;
    state == ST_FIRING && pulseLeft == PULSE_ONE && !trig && !dis;
  endsequence

  property p_countDown;
    s_midTick |=> ticksLeft == $past(ticksLeft) - TICKS_ONE && timerRunning;
  endproperty
  a_countDown: assert property (p_countDown) else $error("base tick did not count down");

  // between ticks the count must not drift, or the interval would shrink
  property p_holdCount;
    state == ST_RUNNING && !tk.tick && !trig && !dis
      |=> ticksLeft == $past(ticksLeft) && timerRunning;
  endproperty
  a_holdCount: assert property (p_holdCount) else $error("count moved between ticks");

  // the prescaler needs at least four cycles per base tick
  property p_tickGap;
    tk.tick |=> !tk.tick [*3];
  endproperty
  a_tickGap: assert property (p_tickGap) else $error("base ticks too close");

  property p_pulseDone;
    s_lastPulse |=> state == ST_STOPPED && !sysReset && !nmiEvent && !timerRunning;
  endproperty
  a_pulseDone: assert property (p_pulseDone) else $error("expiry pulse did not end");

  // the route follows the strap for as long as the pulse lasts
  property p_route;
    state == ST_FIRING && pulseLeft != PULSE_ONE && !trig && !dis
      |=> nmiEvent == $past(nmiRouteJumper) && sysReset == !$past(nmiRouteJumper);
  endproperty
  a_route: assert property (p_route) else $error("pulse on wrong output");

  // a stopped timer stays silent until the next trigger
  property p_stoppedQuiet;
    state == ST_STOPPED && !trig |=> !sysReset && !nmiEvent && !timerRunning;
  endproperty
  a_stoppedQuiet: assert property (p_stoppedQuiet) else $error("stopped timer not quiet");
endmodule

// [dv/iowdt_host_model.sv]
`timescale 1ns/1ps
module iowdt_host_model (
  // clock
  input wire logic core_clk,
  // host i/o read cycle
  output logic [iowdt_pkg::ADDR_W-1:0] ioAddr,
  output logic ioRead
);
  import iowdt_pkg::*;
  // idle bus at time zero
  initial begin
    ioAddr = 16'h0000;
    ioRead = 1'b0;
  end
  // one read cycle, launched on the falling edge and held across one sampling edge
  task automatic do_read(input logic [ADDR_W-1:0] addr);
    @(negedge core_clk);
    ioAddr = addr;
    ioRead = 1'b1;
    @(negedge core_clk);
    ioRead = 1'b0;
    ioAddr = ~addr; // released bus must not keep showing the last address
  endtask
  // periodic retrigger; the caller keeps gap inside seventy percent of the interval
  task automatic keepalive(input logic [ADDR_W-1:0] addr, input int gap, input int count);
    repeat (count) begin
      do_read(addr);
      repeat (gap) @(negedge core_clk);
    end
  endtask
endmodule

// [dv/tb_io_read_watchdog_timer.sv]
`timescale 1ns/1ps
module tb_io_read_watchdog_timer;
  import iowdt_pkg::*;
  // short counts keep the run brief; expectations derive from these
  localparam int TICK = 8;
  localparam int PLEN = 4;
  logic core_clk;
  logic rst;
  logic [ADDR_W-1:0] ioAddr;
  logic ioRead;
  logic [2:0] rangeSel;
  logic nmiRouteJumper;
  logic sysReset;
  logic nmiEvent;
  logic timerRunning;
  logic [1:0] expKind[$];
  int expCyc[$];
  logic [1:0] prevOut = 2'b00;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int hiLen = 0;
  int seed = 46;
  logic jmp;
  logic [ADDR_W-1:0] addr;
  iowdt_host_model host (.core_clk(core_clk), .ioAddr(ioAddr), .ioRead(ioRead));
  io_read_watchdog_timer #(.TICK_CYCLES(TICK), .PULSE_LEN(PLEN)) dut (
    .core_clk(core_clk), .rst(rst), .ioAddr(ioAddr), .ioRead(ioRead),
    .rangeSel(rangeSel), .nmiRouteJumper(nmiRouteJumper),
    .sysReset(sysReset), .nmiEvent(nmiEvent), .timerRunning(timerRunning));
  // ------------------------------------------------------------------
  // clock, compare and closing tasks
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic compare_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // the pulse must start on the very cycle the interval runs out
  task automatic compare_pulse(input logic [1:0] got, input logic [1:0] exp, input int dt);
    n_tests++;
    if (got !== exp || dt != 0) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h, offset %h", $time, got, exp, dt);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // output monitor: every pulse must match the oldest expectation
  // ------------------------------------------------------------------
  // cycle count follows the sampling edge
  always @(posedge core_clk) cyc++;
  // outputs are read at the falling edge, once they have settled
  always @(negedge core_clk) begin
    if ({nmiEvent, sysReset} !== 2'b00 && prevOut === 2'b00) begin
      if (expKind.size() == 0) compare_pulse({nmiEvent, sysReset}, 2'b00, 0);
      else compare_pulse({nmiEvent, sysReset}, expKind.pop_front(), cyc - expCyc.pop_front());
    end
    if ({nmiEvent, sysReset} !== 2'b00) hiLen++;
    else if (prevOut !== 2'b00) begin
      compare_bit(hiLen == PLEN, 1'b1);
      hiLen = 0;
    end
    prevOut = {nmiEvent, sysReset};
  end
  // watchdog: about eight times the length of the whole run
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end
  // ------------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------------
  initial begin
    rangeSel = 3'h0;
    nmiRouteJumper = 1'b0;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    // every range, both trigger ports, random jumper
    for (int n = 0; n < 8; n++) begin
      jmp = 1'($random(seed));
      rangeSel = 3'(n);
      nmiRouteJumper = jmp;
      host.do_read(n[0] ? TIMER_TRIGGER_PORT_B : TIMER_TRIGGER_PORT_A);
      expKind.push_back(jmp ? 2'b10 : 2'b01);
      expCyc.push_back(cyc + (TICK << n) + 1);
      @(negedge core_clk);
      compare_bit(timerRunning, 1'b1);
      repeat ((TICK << n) + PLEN + 8) @(negedge core_clk);
      compare_bit(timerRunning, 1'b0);
      compare_bit(expKind.size() == 0, 1'b1);
    end
    $display("test ranges done");
    // unmapped random addresses must not start the timer
    repeat (6) begin
      addr = 16'($random(seed)) | 16'h1000;
      host.do_read(addr);
      @(negedge core_clk);
      compare_bit(timerRunning, 1'b0);
    end
    $display("test unmapped done");
    // late retriggers must restart the full count, then disable must silence it
    rangeSel = 3'h2;
    nmiRouteJumper = 1'b0;
    host.keepalive(TIMER_TRIGGER_PORT_A, (TICK << 2) * 6 / 10, 6);
    compare_bit(timerRunning, 1'b1);
    host.do_read(TIMER_DISABLE_PORT_B);
    @(negedge core_clk);
    compare_bit(timerRunning, 1'b0);
    host.do_read(TIMER_TRIGGER_PORT_B);
    host.do_read(TIMER_DISABLE_PORT_A);
    @(negedge core_clk);
    compare_bit(timerRunning, 1'b0);
    repeat ((TICK << 2) * 3) @(negedge core_clk);
    compare_bit(timerRunning, 1'b0);
    // a retrigger just before expiry restarts the full interval from itself
    rangeSel = 3'h1;
    jmp = 1'($random(seed));
    nmiRouteJumper = jmp;
    host.do_read(TIMER_TRIGGER_PORT_A);
    repeat ((TICK << 1) - 3) @(negedge core_clk);
    host.do_read(TIMER_TRIGGER_PORT_B);
    expKind.push_back(jmp ? 2'b10 : 2'b01);
    expCyc.push_back(cyc + (TICK << 1) + 1);
    repeat ((TICK << 1) + PLEN + 8) @(negedge core_clk);
    compare_bit(expKind.size() == 0, 1'b1);
    compare_bit(timerRunning, 1'b0);
    $display("test retrigger and disable done");
    stop_test();
  end
endmodule
